// >>> cigm_core.v
// Instruction group decoder and executor with unsigned multiply, APB slave.
// Overview of operation
// - Multiply puts high byte in X, low in A
// - Multiply clears H and C, keeps I N Z
// - Multiply is opcode 42, eleven cycles
// - Register/memory ops use A or X plus memory
// - Jump and call use only effective address
// - Branch changes flow only if condition holds
// - Every branch is two bytes long, bit test branch three
// - Bit set/clear reach any page zero bit
// - One instruction tests page zero bit, branches
// - Tested bit is copied into carry always
// - Read/modify/write writes result back in place
// - Test instruction updates flags, never writes
// - Control ops touch processor registers only
// - Decode all basic instructions into five classes
// - Add sets half carry from bit three
// - Masked interrupts stay pending until unmasked
`include "cigm_defs.vh"
`default_nettype none
module cigm_core (
	input  wire        pclk,
	input  wire        presetn,
	input  wire [11:0] paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        irq_n,
	output wire        irq_take,
	output wire        busy
);
	reg  [7:0]  acc_r;
	reg  [7:0]  idx_r;
	reg  [4:0]  ccr_r;
	reg  [15:0] pc_r;
	reg  [23:0] instr_r;
	reg  [7:0]  ext_rd_r;
	reg  [15:0] ext_waddr_r;
	reg  [7:0]  ext_wdata_r;
	reg         ext_wr_r;
	reg  [15:0] eaddr_r;
	reg         busy_r;
	reg  [3:0]  cnt_r;
	reg         ill_r;
	reg         taken_r;
	reg  [2:0]  cls_r;
	reg  [1:0]  len_r;
	reg  [3:0]  cyc_r;
	reg         pend_r;
	reg         irq_n_meta_r;
	reg         irq_n_sync_r;
	reg         irq_n_prev_r;
	reg  [7:0]  mem [0:255];
	reg  [15:0] ea;
	reg  [7:0]  n_a;
	reg  [7:0]  n_x;
	reg  [4:0]  n_c;
	reg  [15:0] n_pc;
	reg         wr;
	reg  [7:0]  wdat;
	reg  [2:0]  cls;
	reg  [1:0]  len;
	reg  [3:0]  cyc;
	reg         ill;
	reg         tk;
	reg         jump_op;
	reg         nz;
	reg  [7:0]  v;
	reg  [7:0]  r;
	reg  [7:0]  opreg;
	reg  [8:0]  s9;
	reg  [4:0]  h5;
	reg         cin;
	reg         base;
	reg  [31:0] rd_nxt;
	wire [7:0]  op  = instr_r[7:0];
	wire [7:0]  op1 = instr_r[15:8];
	wire [7:0]  op2 = instr_r[23:16];
	wire [3:0]  hi  = op[7:4];
	wire [3:0]  lo  = op[3:0];
	wire [7:0]  mval;
	wire [7:0]  bmask;
	wire        bitv;
	wire [15:0] prod;
	wire [7:0]  off;
	wire        acc_wr;
	wire        mem_sel;
	wire        reg_sel;
	wire        start;
	wire        commit;
	wire        irq_edge;

	// Exact product, no overflow is possible in sixteen bits.
	assign prod  = {8'h00, acc_r} * {8'h00, idx_r};
	// Operands outside page zero come from the external read register.
	assign mval  = (ea[15:8] == 8'h00) ? mem[ea[7:0]] : ext_rd_r;
	assign bmask = 8'h01 << op[3:1];
	assign bitv  = |(mval & bmask);
	assign off   = (hi == 4'h0) ? op2 : op1;

	// Effective address per addressing mode of the opcode's row.
	always @* begin
		case (hi)
		4'h0, 4'h1, 4'h3, 4'hB: ea = {8'h00, op1};
		4'hC:                   ea = {op1, op2};
		4'hD:                   ea = {op1, op2} + {8'h00, idx_r};
		4'hE, 4'h6:             ea = {8'h00, op1} + {8'h00, idx_r};
		default:                ea = {8'h00, idx_r};
		endcase
	end

	// Decode and compute the complete effect of the held instruction.
	always @* begin
		n_a   = acc_r;
		n_x   = idx_r;
		n_c   = ccr_r;
		wr    = 1'b0;
		wdat  = 8'h00;
		cls   = `CIGM_CLS_NONE;
		len   = 2'h1;
		cyc   = `CIGM_CYC_ILLEGAL;
		ill   = 1'b0;
		tk    = 1'b0;
		jump_op   = 1'b0;
		nz    = 1'b0;
		v     = mval;
		r     = 8'h00;
		opreg = acc_r;
		s9    = 9'h000;
		h5    = 5'h00;
		cin   = ccr_r[`CIGM_CCR_C];
		base  = 1'b0;
		case (hi)
		4'h0: begin
			cls = `CIGM_CLS_BITMAN;
			len = 2'h3;
			cyc = `CIGM_CYC_BITBR;
			n_c[`CIGM_CCR_C] = bitv;
			tk = bitv ^ op[0];
		end
		4'h1: begin
			cls = `CIGM_CLS_BITMAN;
			len = 2'h2;
			cyc = `CIGM_CYC_BITSET;
			wr  = 1'b1;
			wdat = op[0] ? (mval & ~bmask) : (mval | bmask);
		end
		4'h2: begin
			cls = `CIGM_CLS_BRANCH;
			len = 2'h2;
			cyc = `CIGM_CYC_BRANCH;
			case (op[3:1])
			3'h0: base = 1'b1;
			3'h1: base = ~(ccr_r[`CIGM_CCR_C] | ccr_r[`CIGM_CCR_Z]);
			3'h2: base = ~ccr_r[`CIGM_CCR_C];
			3'h3: base = ~ccr_r[`CIGM_CCR_Z];
			3'h4: base = ~ccr_r[`CIGM_CCR_H];
			3'h5: base = ~ccr_r[`CIGM_CCR_N];
			3'h6: base = ~ccr_r[`CIGM_CCR_I];
			default: base = ~irq_n_sync_r;
			endcase
			tk = base ^ op[0];
		end
		4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
			if (op == `CIGM_OP_MUL) begin
				cls = `CIGM_CLS_CTRL;
				cyc = `CIGM_CYC_MUL;
				n_x = prod[15:8];
				n_a = prod[7:0];
				n_c[`CIGM_CCR_H] = 1'b0;
				n_c[`CIGM_CCR_C] = 1'b0;
			end else begin
				cls = `CIGM_CLS_RMW;
				v = (hi == 4'h4) ? acc_r : (hi == 4'h5) ? idx_r : mval;
				nz = 1'b1;
				case (hi)
				4'h3: begin len = 2'h2; cyc = `CIGM_CYC_RMW_DIR; end
				4'h6: begin len = 2'h2; cyc = `CIGM_CYC_RMW_IX1; end
				4'h7: cyc = `CIGM_CYC_RMW_IX;
				default: cyc = `CIGM_CYC_RMW_INH;
				endcase
				case (lo)
				4'h0: begin r = 8'h00 - v; n_c[`CIGM_CCR_C] = |r; end
				4'h3: begin r = ~v; n_c[`CIGM_CCR_C] = 1'b1; end
				4'h4: begin r = {1'b0, v[7:1]}; n_c[`CIGM_CCR_C] = v[0]; end
				4'h6: begin r = {cin, v[7:1]}; n_c[`CIGM_CCR_C] = v[0]; end
				4'h7: begin r = {v[7], v[7:1]}; n_c[`CIGM_CCR_C] = v[0]; end
				4'h8: begin r = {v[6:0], 1'b0}; n_c[`CIGM_CCR_C] = v[7]; end
				4'h9: begin r = {v[6:0], cin}; n_c[`CIGM_CCR_C] = v[7]; end
				4'hA: r = v - 8'h01;
				4'hC: r = v + 8'h01;
				4'hD: r = v;
				4'hF: r = 8'h00;
				default: ill = 1'b1;
				endcase
				// The test opcode only reads, so it saves the write cycle.
				if (lo == 4'hD) begin
					if (hi != 4'h4 && hi != 4'h5)
						cyc = cyc - `CIGM_CYC_TST_SAV;
				end else if (hi == 4'h4) begin
					n_a = r;
				end else if (hi == 4'h5) begin
					n_x = r;
				end else begin
					wr   = 1'b1;
					wdat = r;
				end
			end
		end
		4'h8, 4'h9: begin
			// Register-only operations, never an address or memory byte.
			cls = `CIGM_CLS_CTRL;
			cyc = `CIGM_CYC_CTRL;
			case (op)
			`CIGM_OP_TAX: n_x = acc_r;
			`CIGM_OP_TXA: n_a = idx_r;
			`CIGM_OP_CLC: n_c[`CIGM_CCR_C] = 1'b0;
			`CIGM_OP_SEC: n_c[`CIGM_CCR_C] = 1'b1;
			`CIGM_OP_CLI: n_c[`CIGM_CCR_I] = 1'b0;
			`CIGM_OP_SEI: n_c[`CIGM_CCR_I] = 1'b1;
			`CIGM_OP_NOP: n_c = ccr_r;
			default: ill = 1'b1;
			endcase
		end
		default: begin
			cls = `CIGM_CLS_REGMEM;
			v = (hi == 4'hA) ? op1 : mval;
			opreg = (lo == 4'h3 || lo == 4'hE || lo == 4'hF) ?
				idx_r : acc_r;
			nz = 1'b1;
			case (hi)
			4'hA: begin len = 2'h2; cyc = `CIGM_CYC_IMM; end
			4'hB: begin len = 2'h2; cyc = `CIGM_CYC_DIR; end
			4'hC: begin len = 2'h3; cyc = `CIGM_CYC_EXT; end
			4'hD: begin len = 2'h3; cyc = `CIGM_CYC_IX2; end
			4'hE: begin len = 2'h2; cyc = `CIGM_CYC_IX1; end
			default: cyc = `CIGM_CYC_IX;
			endcase
			if (lo == 4'h0 || lo == 4'h1 || lo == 4'h3)
				cin = 1'b0;
			if (lo == 4'h9 || lo == 4'hB) begin
				cin = (lo == 4'h9) & ccr_r[`CIGM_CCR_C];
				s9  = {1'b0, opreg} + {1'b0, v} + {8'h00, cin};
				h5  = {1'b0, opreg[3:0]} + {1'b0, v[3:0]} + {4'h0, cin};
			end else begin
				s9  = {1'b0, opreg} - {1'b0, v} - {8'h00, cin};
			end
			case (lo)
			4'h0, 4'h2: begin r = s9[7:0]; n_a = r; end
			4'h1, 4'h3: r = s9[7:0];
			4'h4: begin r = opreg & v; n_a = r; end
			4'h5: r = opreg & v;
			4'h6: begin r = v; n_a = r; end
			4'hE: begin r = v; n_x = r; end
			4'h8: begin r = opreg ^ v; n_a = r; end
			4'hA: begin r = opreg | v; n_a = r; end
			4'h9, 4'hB: begin
				r = s9[7:0];
				n_a = r;
				n_c[`CIGM_CCR_H] = h5[4];
			end
			4'h7, 4'hF: begin
				r = opreg;
				wr = 1'b1;
				wdat = opreg;
				cyc = cyc + `CIGM_CYC_ST_ADD;
			end
			4'hC: begin
				jump_op = 1'b1;
				nz = 1'b0;
				cyc = cyc - `CIGM_CYC_JMP_SUB;
			end
			default: begin
				jump_op = 1'b1;
				nz = 1'b0;
				cyc = cyc + `CIGM_CYC_JSR_ADD;
			end
			endcase
			if (lo <= 4'h3 || lo == 4'h9 || lo == 4'hB)
				n_c[`CIGM_CCR_C] = s9[8];
			// Stores, jumps and calls have no immediate form.
			if (hi == 4'hA && (lo == 4'h7 || lo >= 4'hC && lo != 4'hE))
				ill = 1'b1;
		end
		endcase
		if (nz) begin
			n_c[`CIGM_CCR_N] = r[7];
			n_c[`CIGM_CCR_Z] = (r == 8'h00);
		end
		// Flow: jump target, or step past the bytes plus a taken offset.
		if (jump_op)
			n_pc = ea;
		else
			n_pc = pc_r + {14'h0000, len} +
				(tk ? {{8{off[7]}}, off} : 16'h0000);
		// An unknown opcode changes nothing, not even the program counter.
		if (ill) begin
			n_a = acc_r;
			n_x = idx_r;
			n_c = ccr_r;
			n_pc = pc_r;
			wr = 1'b0;
			tk = 1'b0;
			cls = `CIGM_CLS_NONE;
			cyc = `CIGM_CYC_ILLEGAL;
		end
	end

	// APB decode; the slave never waits, so pready is a constant high.
	assign pready  = 1'b1;
	assign mem_sel = (paddr[11:10] == `CIGM_MEM_REGION) &&
		(paddr[1:0] == 2'h0);
	assign reg_sel = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0) &&
		(paddr <= `CIGM_OFF_EADDR);
	assign pslverr = psel & penable & ~mem_sel & ~reg_sel;
	assign acc_wr  = psel & penable & pwrite & ~busy_r;
	assign start   = acc_wr & (paddr == `CIGM_OFF_CTRL) & pwdata[0];
	assign commit  = busy_r & (cnt_r == 4'h1);
	assign busy    = busy_r;

	// Interrupt requests latch and wait while the mask bit is set.
	assign irq_edge = irq_n_prev_r & ~irq_n_sync_r;
	assign irq_take = pend_r & ~ccr_r[`CIGM_CCR_I] & ~busy_r;

	// Read data is captured in the setup phase so it is stable at access.
	always @* begin
		case (paddr)
		`CIGM_OFF_STATUS: rd_nxt = {18'h0_0000, cyc_r, len_r, cls_r,
			pend_r, ext_wr_r, taken_r, ill_r, busy_r};
		`CIGM_OFF_INSTR:  rd_nxt = {8'h00, instr_r};
		`CIGM_OFF_ACC:    rd_nxt = {24'h00_0000, acc_r};
		`CIGM_OFF_IDX:    rd_nxt = {24'h00_0000, idx_r};
		`CIGM_OFF_CCR:    rd_nxt = {27'h000_0000, ccr_r};
		`CIGM_OFF_PC:     rd_nxt = {16'h0000, pc_r};
		`CIGM_OFF_EXT_RD: rd_nxt = {24'h00_0000, ext_rd_r};
		`CIGM_OFF_EXT_WR: rd_nxt = {8'h00, ext_wdata_r, ext_waddr_r};
		`CIGM_OFF_EADDR:  rd_nxt = {16'h0000, eaddr_r};
		default:          rd_nxt = 32'h0000_0000;
		endcase
		if (mem_sel)
			rd_nxt = {24'h00_0000, mem[paddr[9:2]]};
	end

	// Page zero storage; no reset, software initialises what it uses.
	always @(posedge pclk) begin
		if (commit && wr && ea[15:8] == 8'h00)
			mem[ea[7:0]] <= wdat;
		else if (acc_wr && mem_sel)
			mem[paddr[9:2]] <= pwdata[7:0];
	end

	// Two-stage synchroniser for the external interrupt pin.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_n_meta_r <= 1'b1;
			irq_n_sync_r <= 1'b1;
			irq_n_prev_r <= 1'b1;
			pend_r       <= 1'b0;
		end else begin
			irq_n_meta_r <= irq_n;
			irq_n_sync_r <= irq_n_meta_r;
			irq_n_prev_r <= irq_n_sync_r;
			pend_r       <= irq_edge | (pend_r & ~irq_take);
		end
	end

	// Sequencer and registers; software writes are ignored while busy.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_r       <= 8'h00;
			idx_r       <= 8'h00;
			ccr_r       <= `CIGM_CCR_RST;
			pc_r        <= `CIGM_PC_RST;
			instr_r     <= 24'h00_0000;
			ext_rd_r    <= 8'h00;
			ext_waddr_r <= 16'h0000;
			ext_wdata_r <= 8'h00;
			ext_wr_r    <= 1'b0;
			eaddr_r     <= 16'h0000;
			busy_r      <= 1'b0;
			cnt_r       <= 4'h0;
			ill_r       <= 1'b0;
			taken_r     <= 1'b0;
			cls_r       <= `CIGM_CLS_NONE;
			len_r       <= 2'h0;
			cyc_r       <= 4'h0;
			prdata      <= 32'h0000_0000;
		end else begin
			if (psel && !penable)
				prdata <= rd_nxt;
			if (start) begin
				busy_r   <= 1'b1;
				cnt_r    <= cyc;
				cyc_r    <= cyc;
				cls_r    <= cls;
				len_r    <= len;
				ill_r    <= ill;
				taken_r  <= tk;
				eaddr_r  <= ea;
				ext_wr_r <= 1'b0;
			end else if (busy_r) begin
				cnt_r <= cnt_r - 4'h1;
				if (commit)
					busy_r <= 1'b0;
			end
			if (commit) begin
				acc_r <= n_a;
				idx_r <= n_x;
				ccr_r <= n_c;
				pc_r  <= n_pc;
				if (wr && ea[15:8] != 8'h00) begin
					ext_wr_r    <= 1'b1;
					ext_waddr_r <= ea;
					ext_wdata_r <= wdat;
				end
			end else if (acc_wr) begin
				case (paddr)
				`CIGM_OFF_INSTR:  instr_r  <= pwdata[23:0];
				`CIGM_OFF_ACC:    acc_r    <= pwdata[7:0];
				`CIGM_OFF_IDX:    idx_r    <= pwdata[7:0];
				`CIGM_OFF_CCR:    ccr_r    <= pwdata[4:0];
				`CIGM_OFF_PC:     pc_r     <= pwdata[15:0];
				`CIGM_OFF_EXT_RD: ext_rd_r <= pwdata[7:0];
				default:          ext_rd_r <= ext_rd_r;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// >>> cigm_core_monitor.sv
// Port-level checker for the instruction core and its register bus.
`default_nettype none
module cigm_core_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq_n,
	input wire logic        irq_take,
	input wire logic        busy
);
	logic [7:0] op_r;
	logic [4:0] cnt_r;
	logic       acc_w;
	logic       start_w;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Writes made while busy are dropped by the core, so ignore them too.
	assign acc_w   = psel && penable && pwrite && !busy;
	assign start_w = acc_w && paddr == 12'h000 && pwdata[0];

	// Remember the held opcode and count how long busy stays high.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_r  <= 8'h00;
			cnt_r <= 5'h00;
		end else begin
			if (acc_w && paddr == 12'h008)
				op_r <= pwdata[7:0];
			cnt_r <= busy ? cnt_r + 5'h01 : 5'h00;
		end
	end

	mul_length_a: assert property (
		$fell(busy) && op_r == 8'h42 |-> cnt_r == 5'h0B)
		else $error("multiply did not last eleven cycles");
	branch_length_a: assert property (
		$fell(busy) && op_r[7:4] == 4'h2 |-> cnt_r == 5'h03)
		else $error("branch did not last three cycles");
	bit_length_a: assert property (
		$fell(busy) && op_r[7:5] == 3'h0 |-> cnt_r == 5'h05)
		else $error("bit operation did not last five cycles");
	start_busy_a: assert property (
		start_w |-> ##[1:2] busy)
		else $error("start did not raise busy");
	ready_high_a: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("error response outside access phase");
	err_unmapped_a: assert property (
		psel && penable && paddr == 12'h300 |-> pslverr)
		else $error("unmapped access not refused");
	err_data_a: assert property (
		psel && penable && !pwrite && pslverr |-> prdata == 32'h0000_0000)
		else $error("refused read returned data");
	irq_idle_a: assert property (irq_take |-> !busy)
		else $error("interrupt taken during an instruction");

	cover property (start_w && op_r == 8'h42);
	cover property (pslverr);
	cover property (irq_take);
endmodule

bind cigm_core cigm_core_monitor i_cigm_core_monitor (
	.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
	.prdata, .pready, .pslverr, .irq_n, .irq_take, .busy);
`default_nettype wire

// >>> cigm_defs.vh
// Shared constants for the instruction group decoder and multiplier.
`ifndef CIGM_DEFS_VH
`define CIGM_DEFS_VH
// Register byte offsets on the APB bus.
`define CIGM_OFF_CTRL    12'h000
`define CIGM_OFF_STATUS  12'h004
`define CIGM_OFF_INSTR   12'h008
`define CIGM_OFF_ACC     12'h00C
`define CIGM_OFF_IDX     12'h010
`define CIGM_OFF_CCR     12'h014
`define CIGM_OFF_PC      12'h018
`define CIGM_OFF_EXT_RD  12'h01C
`define CIGM_OFF_EXT_WR  12'h020
`define CIGM_OFF_EADDR   12'h024
// Page zero memory window: paddr[11:10] equal to this value.
`define CIGM_MEM_REGION  2'h1
// Condition code bit positions and reset value.
`define CIGM_CCR_H       4
`define CIGM_CCR_I       3
`define CIGM_CCR_N       2
`define CIGM_CCR_Z       1
`define CIGM_CCR_C       0
`define CIGM_CCR_RST     5'h08
`define CIGM_PC_RST      16'h0000
// Opcodes with fixed encodings.
`define CIGM_OP_MUL      8'h42
`define CIGM_OP_TAX      8'h97
`define CIGM_OP_CLC      8'h98
`define CIGM_OP_SEC      8'h99
`define CIGM_OP_CLI      8'h9A
`define CIGM_OP_SEI      8'h9B
`define CIGM_OP_NOP      8'h9D
`define CIGM_OP_TXA      8'h9F
// Instruction classes shown in the status register.
`define CIGM_CLS_NONE    3'h0
`define CIGM_CLS_REGMEM  3'h1
`define CIGM_CLS_RMW     3'h2
`define CIGM_CLS_BRANCH  3'h3
`define CIGM_CLS_BITMAN  3'h4
`define CIGM_CLS_CTRL    3'h5
// Execution lengths in processor cycles.
`define CIGM_CYC_MUL     4'hB
`define CIGM_CYC_BRANCH  4'h3
`define CIGM_CYC_BITBR   4'h5
`define CIGM_CYC_BITSET  4'h5
`define CIGM_CYC_RMW_DIR 4'h5
`define CIGM_CYC_RMW_INH 4'h3
`define CIGM_CYC_RMW_IX1 4'h6
`define CIGM_CYC_RMW_IX  4'h5
`define CIGM_CYC_TST_SAV 4'h1
`define CIGM_CYC_CTRL    4'h2
`define CIGM_CYC_ILLEGAL 4'h1
`define CIGM_CYC_IMM     4'h2
`define CIGM_CYC_DIR     4'h3
`define CIGM_CYC_EXT     4'h4
`define CIGM_CYC_IX2     4'h5
`define CIGM_CYC_IX1     4'h4
`define CIGM_CYC_IX      4'h3
`define CIGM_CYC_ST_ADD  4'h1
`define CIGM_CYC_JMP_SUB 4'h1
`define CIGM_CYC_JSR_ADD 4'h2
`endif

// >>> cigm_tb.sv
// Self-checking bench for the instruction core over its register bus.
`default_nettype none
`include "cigm_defs.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// Bit opcodes are not in the shared constants; values are plain defaults.
	localparam logic [7:0] OP_BSET0  = 8'h10;
	localparam logic [7:0] OP_BRSET0 = 8'h00;
	logic        pclk, presetn, psel, penable, pwrite, irq_n;
	logic        pready, pslverr, irq_take, busy, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int          fail_count = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          takes = 0;

	cigm_core i_cigm_core (.pclk, .presetn, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .irq_n,
		.irq_take, .busy);

	// Free-running processor clock.
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// Count takes in the background, since a take lasts a single cycle.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (irq_take === 1'b1)
			takes <= takes + 1;
		if (cyc == 5000) begin
			fail_count++;
			final_report();
		end
	end

	task automatic final_report();
		if (fail_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One bus transfer; the request holds until ready is seen high.
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask

	// Load an instruction, start it and wait for busy to drop.
	task automatic run(input logic [7:0] op, b1, b2);
		int n;
		xfer(1'b1, `CIGM_OFF_INSTR, {8'h00, b2, b1, op});
		xfer(1'b1, `CIGM_OFF_CTRL, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		n = 0;
		while (busy !== 1'b0 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		chk(n < 40, 1'b1);
	endtask

	task automatic t_mul();
		logic [7:0]  a[3] = '{8'hFF, 8'h00, 8'h12};
		logic [7:0]  x[3] = '{8'hFF, 8'h5A, 8'h34};
		logic [15:0] p;
		for (int i = 0; i < 3; i++) begin
			p = a[i] * x[i];
			xfer(1'b1, `CIGM_OFF_ACC, {24'h0, a[i]});
			xfer(1'b1, `CIGM_OFF_IDX, {24'h0, x[i]});
			xfer(1'b1, `CIGM_OFF_CCR, 32'h0000_001F);
			xfer(1'b1, `CIGM_OFF_PC, 32'h0000_0200);
			run(8'h42, 8'h00, 8'h00);
			rdchk(`CIGM_OFF_ACC, {24'h0, p[7:0]});
			rdchk(`CIGM_OFF_IDX, {24'h0, p[15:8]});
			rdchk(`CIGM_OFF_CCR, 32'h0000_000E);
			rdchk(`CIGM_OFF_PC, 32'h0000_0201);
			xfer(1'b0, `CIGM_OFF_STATUS, 32'h0000_0000);
			chk(rd[13:10], 4'hB);
		end
	endtask

	// Taken and untaken branches, with a backward offset.
	task automatic t_branch();
		logic [7:0]  op[4] = '{8'h27, 8'h26, 8'h20, 8'h21};
		logic [7:0]  ofs[4] = '{8'hF0, 8'hF0, 8'h7F, 8'h7F};
		logic [15:0] pc[4] = '{16'h00F2, 16'h0102, 16'h0181, 16'h0102};
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, `CIGM_OFF_CCR, 32'h0000_0002);
			xfer(1'b1, `CIGM_OFF_PC, 32'h0000_0100);
			run(op[i], ofs[i], 8'h00);
			rdchk(`CIGM_OFF_PC, {16'h0, pc[i]});
			rdchk(`CIGM_OFF_CCR, 32'h0000_0002);
		end
	endtask

	task automatic t_ops();
		xfer(1'b1, `CIGM_OFF_CCR, 32'h0000_0000);
		run(8'hA6, 8'h3C, 8'h00);
		run(8'hB7, 8'h20, 8'h00);
		rdchk(12'h480, 32'h0000_003C);
		run(8'hAB, 8'h04, 8'h00);
		rdchk(`CIGM_OFF_ACC, 32'h0000_0040);
		rdchk(`CIGM_OFF_CCR, 32'h0000_0010);
		run(8'hCC, 8'h12, 8'h34);
		rdchk(`CIGM_OFF_PC, 32'h0000_1234);
		rdchk(`CIGM_OFF_ACC, 32'h0000_0040);
		run(OP_BSET0, 8'h20, 8'h00);
		rdchk(12'h480, 32'h0000_003D);
		run(OP_BRSET0, 8'h20, 8'h04);
		rdchk(`CIGM_OFF_PC, 32'h0000_123D);
		rdchk(`CIGM_OFF_CCR, 32'h0000_0011);
		run(8'h98, 8'h00, 8'h00);
		rdchk(`CIGM_OFF_CCR, 32'h0000_0010);
		run(8'h97, 8'h00, 8'h00);
		rdchk(`CIGM_OFF_IDX, 32'h0000_0040);
	endtask

	// Read/modify/write, test, an unknown opcode and far operands.
	task automatic t_rmw();
		xfer(1'b1, 12'h484, 32'h0000_0080);
		run(8'h3C, 8'h20, 8'h00);
		rdchk(12'h480, 32'h0000_003E);
		rdchk(`CIGM_OFF_STATUS, 32'h0000_1640);
		run(8'h3D, 8'h21, 8'h00);
		rdchk(12'h484, 32'h0000_0080);
		rdchk(`CIGM_OFF_CCR, 32'h0000_0014);
		rdchk(`CIGM_OFF_STATUS, 32'h0000_1240);
		run(8'h41, 8'h00, 8'h00);
		rdchk(`CIGM_OFF_PC, 32'h0000_1243);
		rdchk(`CIGM_OFF_STATUS, 32'h0000_0502);
		run(8'hC7, 8'h03, 8'h00);
		rdchk(`CIGM_OFF_EXT_WR, 32'h0040_0300);
		xfer(1'b1, `CIGM_OFF_EXT_RD, 32'h0000_0081);
		run(8'hC6, 8'h03, 8'h00);
		rdchk(`CIGM_OFF_ACC, 32'h0000_0081);
		// A write made while the multiply runs must be dropped.
		xfer(1'b1, `CIGM_OFF_INSTR, 32'h0000_0042);
		xfer(1'b1, `CIGM_OFF_CTRL, 32'h0000_0001);
		xfer(1'b1, `CIGM_OFF_ACC, 32'h0000_0055);
		repeat (12) @(posedge pclk);
		rdchk(`CIGM_OFF_ACC, 32'h0000_0040);
		rdchk(`CIGM_OFF_IDX, 32'h0000_0020);
		rdchk(`CIGM_OFF_CCR, 32'h0000_0004);
	endtask

	// A masked request must wait until the mask is cleared.
	task automatic t_irq();
		xfer(1'b1, `CIGM_OFF_CCR, 32'h0000_0008);
		irq_n <= 1'b0;
		repeat (12) @(posedge pclk);
		chk(takes, 0);
		irq_n <= 1'b1;
		xfer(1'b0, `CIGM_OFF_STATUS, 32'h0000_0000);
		chk(rd[4], 1'b1);
		run(8'h9A, 8'h00, 8'h00);
		repeat (4) @(posedge pclk);
		chk(takes, 1);
		rdchk(`CIGM_OFF_CCR, 32'h0000_0000);
	endtask

	task automatic t_refuse();
		xfer(1'b1, 12'h300, 32'h0000_00AA);
		chk(err, 1'b1);
		xfer(1'b0, 12'h300, 32'h0000_0000);
		chk(err, 1'b1);
		chk(rd, 32'h0000_0000);
	endtask

	// Reset, then each scenario in turn.
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		irq_n = 1'b1;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdchk(`CIGM_OFF_CCR, 32'h0000_0008);
		rdchk(`CIGM_OFF_PC, 32'h0000_0000);
		t_mul();
		t_branch();
		t_ops();
		t_rmw();
		t_irq();
		t_refuse();
		final_report();
	end
endmodule
`default_nettype wire
